// [logic/pmcl_pkg.sv]
// Constants, register map and helpers for the machine control logic
package pmcl_pkg;
  localparam int TMR_W = 16;
  localparam int NFUNC = 2;
  localparam int NZONE = 4;
  localparam int NWORD = 2 * NFUNC + 2 * NZONE;
  localparam int HTR_FIRST = 2 * NFUNC;
  localparam int HTR_LAST = NWORD - 1;
  localparam int NFAULT = 4;
  localparam int ADDR_W = 8;
  localparam int SYNC_W = TMR_W + 3 + NFAULT;
  localparam int CNT_W = 10;
  localparam int WDOG_W = 32;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HTR_ERR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FAULT = 8'h0C;
  localparam logic [7:0] OFS_CYCLE = 8'h10;
  localparam logic [7:0] OFS_ADJ_CMD = 8'h14;
  localparam logic [7:0] OFS_ADJ_SET = 8'h18;
  localparam logic [7:0] OFS_ADJ_OFS = 8'h1C;
  localparam logic [7:0] OFS_ADJ_ACT = 8'h20;
  localparam logic [7:0] OFS_CNT_LO = 8'h24;
  localparam logic [7:0] OFS_CNT_HI = 8'h28;
  localparam logic [7:0] OFS_WORDS = 8'h40;
  // Control and adjust command register bits
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_HEATERS = 1;
  localparam int CTRL_HEAT = 2;
  localparam int CTRL_COOL = 3;
  localparam int CTRL_FRESET = 4;
  localparam int CTRL_MANUAL = 8;
  localparam int ADJ_MOVE = 0;
  localparam int ADJ_ABS = 1;
  // Reset values and counter limit
  localparam logic [TMR_W-1:0] CYCLE_PRESET_RST = 16'h03E8;
  localparam logic [TMR_W-1:0] WORD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_LIMIT = 10'h3E7;
  // Watchdog timeout and bus response codes
  localparam int CLK_MHZ = 100;
  localparam int WDOG_TIME_MS = 100;
  localparam int WDOG_CYCLES_DEF = WDOG_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// [logic/pmcl_sync.sv]
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pmcl_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pmcl_sync_s;
  pmcl_sync_s s;
  pmcl_sync_s n;

  always_comb begin
    n = s;
    n.s1 = din;
    n.s2 = s.s1;
    n.s3 = s.s2;
    // Bits where the later stages disagree keep their old value
    n.q = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dout = s.q;
endmodule

// [logic/pmcl_tmr_if.sv]
// Carrier between the control logic and one timer pair
`timescale 1ns/100ps
interface pmcl_tmr_if;
  logic restart;
  logic [15:0] start_preset;
  logic [15:0] stop_preset;
  logic start_done;
  logic stop_done;
  modport owner (output restart, output start_preset, output stop_preset, input start_done, input stop_done);
  modport timer (input restart, input start_preset, input stop_preset, output start_done, output stop_done);
endinterface

// [logic/pmcl_top.sv]
// Machine control logic: timed functions, heaters, adjustment, counters, faults, AXI4-Lite registers
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module pmcl_top #(
  parameter int WDOG_CYCLES = pmcl_pkg::WDOG_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [pmcl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmcl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pmcl_pkg::NFAULT-1:0] fault_in,
  input wire logic adj_pulse,
  input wire logic adj_home,
  input wire logic adj_err,
  input wire logic [pmcl_pkg::TMR_W-1:0] adj_abs,
  output logic [pmcl_pkg::NFUNC-1:0] func_out,
  output logic [pmcl_pkg::NZONE-1:0] heater_out,
  output logic heat_out,
  output logic cool_out,
  output logic adj_drive,
  output logic adj_dir_up,
  output logic heater_safety
);
  import pmcl_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic auto_mode;
    logic heaters_enabled;
    logic heat_cmd;
    logic cool_cmd;
    logic fault_reset;
    logic [NFUNC-1:0] manual;
    logic [NZONE-1:0] htr_err;
    logic [TMR_W-1:0] cycle_preset;
    logic [TMR_W-1:0] cycle_cnt;
    logic cycle_restart;
    logic [NWORD-1:0][TMR_W-1:0] words;
    logic [NWORD-1:0][TMR_W-1:0] presets;
    logic [NFUNC-1:0] func_out;
    logic [NZONE-1:0] heater_out;
    logic heat_out;
    logic cool_out;
    logic [WDOG_W-1:0] wdog_cnt;
    logic safety;
    logic cnt_prev;
    logic [CNT_W-1:0] cnt_lo;
    logic [CNT_W-1:0] cnt_hi;
    logic [NFAULT-1:0] faults;
    logic adj_drive;
    logic adj_up;
    logic adj_abs_mode;
    logic adj_move_req;
    logic [TMR_W-1:0] setpoint;
    logic [TMR_W-1:0] offset;
    logic [TMR_W-1:0] actual;
    logic pulse_prev;
    logic home_prev;
  } pmcl_state_s;

  pmcl_state_s s;
  pmcl_state_s n;
  logic [SYNC_W-1:0] pins;
  logic [NFAULT-1:0] fault_s;
  logic pulse_s;
  logic home_s;
  logic err_s;
  logic [TMR_W-1:0] abs_s;
  logic [NFUNC+NZONE-1:0] start_done;
  logic [NFUNC+NZONE-1:0] stop_done;
  logic count_pulse;
  logic home_ev;

  pmcl_sync #(.W(SYNC_W)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din({adj_abs, adj_err, adj_home, adj_pulse, fault_in}),
    .dout(pins)
  );
  assign {abs_s, err_s, home_s, pulse_s, fault_s} = pins;

  // One pair per function, then one pair per heater zone
  pmcl_tmr_if tif [NFUNC+NZONE] ();
  for (genvar i = 0; i < NFUNC + NZONE; i++) begin : g_pair
    pmcl_tpair u_pair (
      .mclk(mclk),
      .reset_n(reset_n),
      .tif(tif[i])
    );
    assign tif[i].start_preset = s.presets[2*i];
    assign tif[i].stop_preset = s.presets[2*i+1];
    if (i < NFUNC) begin : g_func
      assign tif[i].restart = s.cycle_restart;
    end else begin : g_zone
      // Zone period is set by its own off timer
      assign tif[i].restart = tif[i].stop_done;
    end
    assign start_done[i] = tif[i].start_done;
    assign stop_done[i] = tif[i].stop_done;
  end

  assign count_pulse = s.func_out[0] & ~s.cnt_prev;
  assign home_ev = home_s & ~s.home_prev;

  always_comb begin
    logic wr_fire;
    logic [ADDR_W-1:0] ra;
    logic [31:0] rd;
    logic rd_ok;
    logic wr_ok;
    logic [31:0] wv;
    wr_fire = 1'b0;
    ra = s_axi_araddr;
    rd = '0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    wv = '0;
    n = s;

    // Write address and data are accepted in either order
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      wr_fire = 1'b1;
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
    end

    // Timer-based functions and heaters
    n.cycle_restart = 1'b0;
    if (s.cycle_cnt >= s.cycle_preset) begin
      n.cycle_cnt = '0;
      n.cycle_restart = 1'b1;
    end else begin
      n.cycle_cnt = 16'(s.cycle_cnt + 16'h0001);
    end
    for (int i = 0; i < NFUNC; i++) begin
      n.func_out[i] = s.auto_mode ? (start_done[i] & ~stop_done[i]) : s.manual[i];
    end
    for (int z = 0; z < NZONE; z++) begin
      n.heater_out[z] = start_done[NFUNC+z] & ~stop_done[NFUNC+z]
        & s.heaters_enabled & s.safety
        & ~s.htr_err[z];
    end
    n.heat_out = s.heat_cmd;
    n.cool_out = s.cool_cmd;
    // Presets only change at this copy, never straight from the bus
    n.presets = s.words;

    // Watchdog restarts on every register write from the PC
    if (wr_fire) begin
      n.wdog_cnt = '0;
    end else if (s.wdog_cnt < WDOG_W'(WDOG_CYCLES)) begin
      n.wdog_cnt = WDOG_W'(s.wdog_cnt + 32'h0000_0001);
    end
    if (s.wdog_cnt >= WDOG_W'(WDOG_CYCLES)) begin
      n.safety = 1'b1;
    end else if (s.fault_reset) begin
      n.safety = 1'b0;
    end

    // Production counter
    n.cnt_prev = s.func_out[0];
    if (count_pulse) begin
      if (s.cnt_lo == CNT_LIMIT) begin
        n.cnt_lo = '0;
        n.cnt_hi = (s.cnt_hi == CNT_LIMIT) ? '0 : CNT_W'(s.cnt_hi + 10'h001);
      end else begin
        n.cnt_lo = CNT_W'(s.cnt_lo + 10'h001);
      end
    end

    // Faults: a new fault wins over a reset in the same cycle
    n.faults = fault_s | (s.faults & {NFAULT{~s.fault_reset}});

    // Adjustment
    n.pulse_prev = pulse_s;
    n.home_prev = home_s;
    if (s.adj_abs_mode) begin
      n.actual = 16'(abs_s - s.offset);
    end else if (pulse_s && !s.pulse_prev) begin
      n.actual = 16'(s.actual + 16'h0001);
    end
    if (s.adj_drive) begin
      n.adj_drive = !err_s && !home_ev && (s.adj_up ? (s.setpoint > s.actual) : (s.setpoint < s.actual));
    end
    if (s.adj_move_req) begin
      n.adj_move_req = 1'b0;
      n.adj_up = s.setpoint > s.actual;
      n.adj_drive = !err_s && (s.setpoint != s.actual);
    end

    // Register writes
    if (wr_fire) begin
      unique case (s.aw_addr)
        OFS_CTRL: begin
          wv = wmerge({22'h0, s.manual, 3'h0, s.fault_reset, s.cool_cmd, s.heat_cmd, s.heaters_enabled,
                       s.auto_mode}, s.wdata, s.wstrb);
          n.auto_mode = wv[CTRL_AUTO];
          n.heaters_enabled = wv[CTRL_HEATERS];
          n.heat_cmd = wv[CTRL_HEAT];
          n.cool_cmd = wv[CTRL_COOL];
          n.fault_reset = wv[CTRL_FRESET];
          n.manual = wv[CTRL_MANUAL +: NFUNC];
        end
        OFS_HTR_ERR: begin
          wv = wmerge({28'h0, s.htr_err}, s.wdata, s.wstrb);
          n.htr_err = wv[NZONE-1:0];
        end
        OFS_CYCLE: begin
          wv = wmerge({16'h0, s.cycle_preset}, s.wdata, s.wstrb);
          n.cycle_preset = wv[TMR_W-1:0];
        end
        OFS_ADJ_CMD: begin
          wv = wmerge({30'h0, s.adj_abs_mode, 1'b0}, s.wdata, s.wstrb);
          n.adj_abs_mode = wv[ADJ_ABS];
          n.adj_move_req = wv[ADJ_MOVE];
        end
        OFS_ADJ_SET: begin
          wv = wmerge({16'h0, s.setpoint}, s.wdata, s.wstrb);
          n.setpoint = wv[TMR_W-1:0];
        end
        OFS_ADJ_OFS: begin
          wv = wmerge({16'h0, s.offset}, s.wdata, s.wstrb);
          n.offset = wv[TMR_W-1:0];
        end
        default: begin
          // Function and heater zone words sit in one contiguous block; the PC writes the heater words as a batch
          if (s.aw_addr >= OFS_WORDS && s.aw_addr < 8'(OFS_WORDS + 8'(4 * NWORD)) && s.aw_addr[1:0] == 2'h0) begin
            wv = wmerge({16'h0, s.words[4'((s.aw_addr - OFS_WORDS) >> 2)]}, s.wdata, s.wstrb);
            n.words[4'((s.aw_addr - OFS_WORDS) >> 2)] = wv[TMR_W-1:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
      endcase
      n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Home after any offset write, so a home in the same cycle wins
    if (home_ev) begin
      if (s.adj_abs_mode) begin
        n.offset = abs_s;
      end else begin
        n.actual = '0;
      end
    end

    // Reads
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      unique case (ra)
        OFS_CTRL: rd = {22'h0, s.manual, 3'h0, s.fault_reset, s.cool_cmd, s.heat_cmd, s.heaters_enabled, s.auto_mode};
        OFS_HTR_ERR: rd = {28'h0, s.htr_err};
        OFS_STATUS: rd = {21'h0, s.safety, s.cool_out, s.heat_out, s.adj_up, s.adj_drive, s.heater_out, s.func_out};
        OFS_FAULT: rd = {28'h0, s.faults};
        OFS_CYCLE: rd = {16'h0, s.cycle_preset};
        OFS_ADJ_CMD: rd = {30'h0, s.adj_abs_mode, 1'b0};
        OFS_ADJ_SET: rd = {16'h0, s.setpoint};
        OFS_ADJ_OFS: rd = {16'h0, s.offset};
        OFS_ADJ_ACT: rd = {16'h0, s.actual};
        OFS_CNT_LO: rd = {22'h0, s.cnt_lo};
        OFS_CNT_HI: rd = {22'h0, s.cnt_hi};
        default: begin
          if (ra >= OFS_WORDS && ra < 8'(OFS_WORDS + 8'(4 * NWORD)) && ra[1:0] == 2'h0) begin
            rd = {16'h0, s.words[4'((ra - OFS_WORDS) >> 2)]};
          end else begin
            rd_ok = 1'b0;
          end
        end
      endcase
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    n.awready = ~n.aw_got;
    n.wready = ~n.w_got;
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.cycle_preset <= CYCLE_PRESET_RST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign func_out = s.func_out;
  assign heater_out = s.heater_out;
  assign heat_out = s.heat_out;
  assign cool_out = s.cool_out;
  assign adj_drive = s.adj_drive;
  assign adj_dir_up = s.adj_up;
  assign heater_safety = s.safety;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_func_auto;
    s.auto_mode && start_done[0] && !stop_done[0] |=> s.func_out[0];
  endproperty
  a_func_auto: assert property (p_func_auto) else $error("auto function output missing");

  property p_func_manual;
    !s.auto_mode && !s.manual[1] |=> !s.func_out[1];
  endproperty
  a_func_manual: assert property (p_func_manual) else $error("manual function output on without bit");

  property p_heater_gate;
    !s.heaters_enabled || !s.safety |=> s.heater_out == '0;
  endproperty
  a_heater_gate: assert property (p_heater_gate) else $error("heater on while not enabled");

  property p_heater_err;
    s.htr_err[0] |=> !s.heater_out[0];
  endproperty
  a_heater_err: assert property (p_heater_err) else $error("heater on with error bit set");

  property p_heat_cool;
    ##1 (s.heat_out == $past(s.heat_cmd)) && (s.cool_out == $past(s.cool_cmd));
  endproperty
  a_heat_cool: assert property (p_heat_cool) else $error("heat or cool output not following command");

  property p_count_edge;
    s.func_out[0] && s.cnt_prev |=> s.cnt_lo == $past(s.cnt_lo);
  endproperty
  a_count_edge: assert property (p_count_edge) else $error("counter moved on a level");

  property p_cascade;
    count_pulse && s.cnt_lo == CNT_LIMIT |=> s.cnt_lo == '0 && s.cnt_hi != $past(s.cnt_hi);
  endproperty
  a_cascade: assert property (p_cascade) else $error("counter cascade failed");

  property p_fault_latch;
    s.faults[0] && !s.fault_reset |=> s.faults[0];
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault bit dropped without reset");

  property p_restart;
    s.cycle_restart |-> ##1 !stop_done[0] || (s.presets[1] == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("function timer not restarted");
endmodule

// [logic/pmcl_tpair.sv]
// Start/stop timer pair, free running and restarted together
`timescale 1ns/100ps
module pmcl_tpair (
  input wire logic mclk,
  input wire logic reset_n,
  pmcl_tmr_if.timer tif
);
  typedef struct packed {
    logic [15:0] start_cnt;
    logic [15:0] stop_cnt;
  } pmcl_tpair_s;
  pmcl_tpair_s s;
  pmcl_tpair_s n;

  always_comb begin
    n = s;
    if (tif.restart) begin
      n.start_cnt = '0;
      n.stop_cnt = '0;
    end else begin
      // Saturate so a long machine cycle never wraps a timer back to not-done
      if (s.start_cnt != 16'hFFFF) begin
        n.start_cnt = 16'(s.start_cnt + 16'h0001);
      end
      if (s.stop_cnt != 16'hFFFF) begin
        n.stop_cnt = 16'(s.stop_cnt + 16'h0001);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tif.start_done = s.start_cnt >= tif.start_preset;
  assign tif.stop_done = s.stop_cnt >= tif.stop_preset;
endmodule

// [tb/plc_machine_control_logic_tb_top.sv]
// Self-checking bench for the machine control logic
`timescale 1ns/100ps
module plc_machine_control_logic_tb_top;
  import pmcl_pkg::*;
  typedef struct {logic [31:0] ctrl; logic [3:0] exp;} pmcl_row_s;
  logic mclk = 1'b0, reset_n = 1'b0, adj_pulse = 1'b0, adj_home = 1'b0, adj_err = 1'b0;
  logic [NFAULT-1:0] fault_in = '0;
  logic [TMR_W-1:0] adj_abs = '0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [NFUNC-1:0] func_out;
  logic [NZONE-1:0] heater_out;
  logic heat_out, cool_out, adj_drive, adj_dir_up, heater_safety;
  int mismatches = 0, tests_run = 0, hi;
  logic [1:0] r;
  logic [15:0] hp [2*NZONE] = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  pmcl_row_s rows [6] = '{'{32'h004, 4'h8}, '{32'h008, 4'h4}, '{32'h00C, 4'hC}, '{32'h100, 4'h1},
    '{32'h200, 4'h2}, '{32'h301, 4'h0}};
  always #5 mclk = ~mclk;
  pmcl_top #(.WDOG_CYCLES(50)) pmcl_top_i (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fault_in, .adj_pulse, .adj_home, .adj_err, .adj_abs, .func_out, .heater_out, .heat_out, .cool_out,
    .adj_drive, .adj_dir_up, .heater_safety);
  pmcl_pc_model pmcl_pc_model_i (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("[FAIL] %0t bus wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string w);
    logic [31:0] d;
    logic [1:0] q;
    pmcl_pc_model_i.rd(a, d, q);
    chk(d, e, w);
    chk({30'h0, q}, {30'h0, er}, w);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    pmcl_pc_model_i.wr(a, d, r);
    chk({30'h0, r}, 32'h0, "write resp");
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pls(input bit home);
    if (home) adj_home <= 1'b1; else adj_pulse <= 1'b1;
    tick(6);
    {adj_home, adj_pulse} <= 2'b00;
    tick(6);
  endtask
  initial begin
    tick(5);
    chk({25'h0, func_out, heater_out, heat_out}, 32'h0, "outputs in reset");
    reset_n <= 1'b1;
    tick(2);
    rc(OFS_CTRL, 32'h0, RESP_OKAY, "ctrl reset");
    rc(OFS_CYCLE, 32'h3E8, RESP_OKAY, "cycle reset");
    rc(OFS_FAULT, 32'h0, RESP_OKAY, "fault reset");
    $display("reset test done");
    // Each write keeps the function high for several cycles, so only edges may count
    for (int i = 0; i < 999; i++) begin
      w(OFS_CTRL, 32'h100);
      w(OFS_CTRL, 32'h000);
    end
    rc(OFS_CNT_LO, 32'h3E7, RESP_OKAY, "cnt lo 999");
    rc(OFS_CNT_HI, 32'h0, RESP_OKAY, "cnt hi 0");
    w(OFS_CTRL, 32'h100);
    w(OFS_CTRL, 32'h000);
    rc(OFS_CNT_LO, 32'h0, RESP_OKAY, "cnt lo wrap");
    rc(OFS_CNT_HI, 32'h1, RESP_OKAY, "cnt hi carry");
    $display("counter test done");
    foreach (rows[i]) begin
      w(OFS_CTRL, rows[i].ctrl);
      tick(3);
      chk({28'h0, heat_out, cool_out, func_out}, {28'h0, rows[i].exp}, "ctrl row");
    end
    $display("table test done");
    w(OFS_WORDS, 32'h000A);
    w(OFS_WORDS + 8'h04, 32'h001E);
    w(OFS_CYCLE, 32'h0064);
    w(OFS_CTRL, 32'h001);
    tick(10);
    hi = 0;
    for (int i = 0; i < 404; i++) begin
      @(posedge mclk);
      hi += int'(func_out[0] === 1'b1);
    end
    chk(32'(hi >= 76 && hi <= 84), 32'h1, "auto window");
    w(OFS_CTRL, 32'h000);
    $display("auto test done");
    rc(8'h30, 32'h0, RESP_SLVERR, "unmapped read");
    pmcl_pc_model_i.wr(OFS_STATUS, 32'hFFFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "read-only write");
    $display("refusal test done");
    fault_in <= 4'h5;
    tick(8);
    fault_in <= 4'h0;
    tick(8);
    rc(OFS_FAULT, 32'h5, RESP_OKAY, "fault latched");
    w(OFS_CTRL, 32'h010);
    w(OFS_CTRL, 32'h000);
    rc(OFS_FAULT, 32'h0, RESP_OKAY, "fault cleared");
    chk({31'h0, heater_safety}, 32'h0, "safety before timeout");
    tick(60);
    chk({31'h0, heater_safety}, 32'h1, "safety after timeout");
    $display("fault and watchdog test done");
    pmcl_pc_model_i.batch(hp, r);
    chk({30'h0, r}, 32'h0, "batch resp");
    w(OFS_CTRL, 32'h002);
    tick(4);
    chk({28'h0, heater_out}, 32'h1, "zone0 on");
    w(OFS_HTR_ERR, 32'h1);
    tick(4);
    chk({28'h0, heater_out}, 32'h0, "zone error");
    w(OFS_HTR_ERR, 32'h0);
    w(OFS_CTRL, 32'h000);
    tick(4);
    chk({28'h0, heater_out}, 32'h0, "heaters disabled");
    $display("heater test done");
    w(OFS_ADJ_SET, 32'h3);
    w(OFS_ADJ_CMD, 32'h1);
    tick(2);
    chk({30'h0, adj_drive, adj_dir_up}, 32'h3, "drive latched up");
    repeat (3) pls(1'b0);
    chk({31'h0, adj_drive}, 32'h0, "drive at setpoint");
    rc(OFS_ADJ_ACT, 32'h3, RESP_OKAY, "pulse actual");
    pls(1'b1);
    rc(OFS_ADJ_ACT, 32'h0, RESP_OKAY, "home clears");
    adj_abs <= 16'h0064;
    w(OFS_ADJ_CMD, 32'h2);
    w(OFS_ADJ_OFS, 32'h1E);
    tick(4);
    rc(OFS_ADJ_ACT, 32'h46, RESP_OKAY, "abs actual");
    pls(1'b1);
    rc(OFS_ADJ_OFS, 32'h64, RESP_OKAY, "home loads offset");
    rc(OFS_ADJ_ACT, 32'h0, RESP_OKAY, "abs after home");
    w(OFS_ADJ_SET, 32'h50);
    w(OFS_ADJ_CMD, 32'h3);
    tick(2);
    chk({31'h0, adj_drive}, 32'h1, "abs drive");
    adj_err <= 1'b1;
    tick(8);
    chk({31'h0, adj_drive}, 32'h0, "error drops drive");
    $display("adjust test done");
    // Safety is still latched here, so the reset check can trip
    reset_n <= 1'b0;
    tick(2);
    chk({24'h0, heater_safety, func_out, heater_out, adj_drive}, 32'h0, "outputs in mid reset");
    reset_n <= 1'b1;
    tick(2);
    rc(OFS_CYCLE, 32'h3E8, RESP_OKAY, "cycle after mid reset");
    rc(OFS_ADJ_OFS, 32'h0, RESP_OKAY, "offset after mid reset");
    $display("mid reset test done");
    final_report();
  end
endmodule

// [tb/pmcl_pc_model.sv]
// Supervisory PC model: AXI4-Lite master for commands, presets and readback
`timescale 1ns/100ps
module pmcl_pc_model (
  input wire logic mclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Released payloads flip so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    for (int n = 0; n < 50 && r === 2'h3; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bready && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (r === 2'h3) plc_machine_control_logic_tb_top.hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h3;
    for (int n = 0; n < 50 && r === 2'h3; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
    if (r === 2'h3) plc_machine_control_logic_tb_top.hang();
  endtask
  // All heater presets go out as one batch over the whole heater range
  task automatic batch(input logic [15:0] p [2*pmcl_pkg::NZONE], output logic [1:0] r);
    logic [1:0] q;
    r = 2'h0;
    for (int i = 0; i < 2 * pmcl_pkg::NZONE; i++) begin
      wr(pmcl_pkg::OFS_WORDS + 8'(4 * (pmcl_pkg::HTR_FIRST + i)), {16'h0000, p[i]}, q);
      r = r | q;
    end
  endtask
endmodule
